// ===== hdl/axs_addr_step.sv
// Next beat address from burst type and size.
// Assumes size never exceeds the data bus width.
`timescale 1ns/1ps
module axs_addr_step
	import axs_pkg::*;
(
	input  wire logic [ADDR_W-1:0] cur_addr,
	input  wire logic [2:0]        size,
	input  wire logic [1:0]        burst,
	input  wire logic [3:0]        len,
	output logic      [ADDR_W-1:0] next_addr
);
	wire logic [ADDR_W-1:0] step_w  = ADDR_W'(1) << size;
	wire logic [ADDR_W-1:0] incr_w  = cur_addr + step_w;
	wire logic [ADDR_W-1:0] span_w  = ADDR_W'({1'b0, len} + 5'h1) << size;
	wire logic [ADDR_W-1:0] mask_w  = span_w - ADDR_W'(1);
	wire logic [ADDR_W-1:0] wrap_w  = (cur_addr & ~mask_w) | (incr_w & mask_w);
	// Fixed bursts repeat the address; wrap bursts stay in their span.
	assign next_addr = (burst == BURST_FIXED) ? cur_addr :
		(burst == BURST_WRAP) ? wrap_w : incr_w; // RULE12
endmodule // axs_addr_step

// ===== hdl/axs_pkg.sv
// Shared constants for the AXI slave endpoint.
// Assumes a single clock shared with the master.
package axs_pkg;
	localparam int ID_W   = 4;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 32;
	localparam int STRB_W = DATA_W / 8;
	localparam int MEM_AW = 6;
	localparam int MEM_WORDS = 64;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_EXOKAY = 2'h1;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	localparam logic [1:0] BURST_FIXED = 2'h0;
	localparam logic [1:0] BURST_INCR  = 2'h1;
	localparam logic [1:0] BURST_WRAP  = 2'h2;
	localparam logic [1:0] LOCK_EXCL   = 2'h1;
	localparam logic [ADDR_W-1:0] MEM_LIMIT = 32'h0000_0100;
	localparam logic [DATA_W-1:0] RST_DATA  = 32'h0000_0000;
	localparam logic [ID_W-1:0]   RST_ID    = 4'h0;
	localparam logic [ADDR_W-1:0] RST_ADDR  = 32'h0000_0000;
	localparam logic [3:0]        RST_LEN   = 4'h0;
endpackage

// ===== hdl/axs_slave.sv
// Function
// RULE1: Write data ID equals write address ID.
// RULE2: Write data bus is 32 bits.
// RULE3: One strobe bit enables each byte.
// RULE4: Write last marks final write beat.
// RULE5: Write valid with data; ready when accepting.
// RULE6: Write response ID equals address ID.
// RULE7: Write status on two-bit response.
// RULE8: Response valid only with real response.
// RULE9: Only start address given for reads.
// RULE10: Return exactly burst-length read beats.
// RULE11: Read size field encodes beat size.
// RULE12: Next address from burst type, size.
// RULE13: Lock, cache, protection travel with address.
// RULE14: Read address held until ready.
// RULE15: Address ready only when able to accept.
// RULE16: Read data ID equals read address ID.
// RULE17: Read data bus is 32 bits.
// RULE18: Every read beat carries a status.
// RULE19: Read last with final read beat.
// RULE20: Read valid only while data presented.
// RULE21: Transfer completes when valid and ready high.
// RULE22: Valid and ready may rise in any order.
// RULE23: Write address held until ready.
// RULE24: Response codes 00, 01, 10, 11.
// RULE25: Burst length is beats minus one.
// AXI slave with a small word memory, one read and one write in flight.
// Assumes the master keeps its side of the handshakes.
`timescale 1ns/1ps
module axs_slave
	import axs_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	input  wire logic [ID_W-1:0]   awid,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic [3:0]        awlen,
	input  wire logic [2:0]        awsize,
	input  wire logic [1:0]        awburst,
	input  wire logic [1:0]        awlock,
	input  wire logic [3:0]        awcache,
	input  wire logic [2:0]        awprot,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [ID_W-1:0]   wid,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [STRB_W-1:0] wstrb,
	input  wire logic              wlast,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic      [ID_W-1:0]   bid,
	output logic      [1:0]        bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ID_W-1:0]   arid,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic [3:0]        arlen,
	input  wire logic [2:0]        arsize,
	input  wire logic [1:0]        arburst,
	input  wire logic [1:0]        arlock,
	input  wire logic [3:0]        arcache,
	input  wire logic [2:0]        arprot,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic      [ID_W-1:0]   rid,
	output logic      [DATA_W-1:0] rdata,
	output logic      [1:0]        rresp,
	output logic                   rlast,
	output logic                   rvalid,
	input  wire logic              rready
);
	typedef enum logic [2:0] {
		WS_ADDR = 3'b001,
		WS_DATA = 3'b010,
		WS_RESP = 3'b100
	} axs_wstate_e;
	typedef enum logic [1:0] {
		RS_ADDR = 2'b01,
		RS_DATA = 2'b10
	} axs_rstate_e;

	axs_wstate_e       ws_reg;
	axs_rstate_e       rs_reg;
	wire logic [DATA_W-1:0] a_word;
	wire logic [DATA_W-1:0] n_word;
	logic [ADDR_W-1:0] waddr_reg;
	logic [2:0]        wsize_reg;
	logic [1:0]        wburst_reg;
	logic [3:0]        wlen_reg;
	logic [3:0]        wcnt_reg;
	logic              werr_reg;
	logic              wexcl_reg;
	logic [ADDR_W-1:0] raddr_reg;
	logic [2:0]        rsize_reg;
	logic [1:0]        rburst_reg;
	logic [3:0]        rlen_reg;
	logic [3:0]        rcnt_reg;
	logic              rexcl_reg;

	// Handshakes complete only when valid and ready meet at an edge.
	wire logic aw_fire = awvalid & awready; // RULE21
	wire logic w_fire  = wvalid & wready;   // RULE21
	wire logic b_fire  = bvalid & bready;   // RULE21
	wire logic ar_fire = arvalid & arready; // RULE21
	wire logic r_fire  = rvalid & rready;   // RULE21

	wire logic [ADDR_W-1:0] w_next;
	wire logic [ADDR_W-1:0] r_next;
	axs_addr_step u_wstep (
		.cur_addr (waddr_reg),
		.size     (wsize_reg),
		.burst    (wburst_reg),
		.len      (wlen_reg),
		.next_addr(w_next)
	);
	axs_addr_step u_rstep (
		.cur_addr (raddr_reg),
		.size     (rsize_reg),
		.burst    (rburst_reg),
		.len      (rlen_reg),
		.next_addr(r_next)
	);

	wire logic [MEM_AW-1:0] w_idx  = waddr_reg[MEM_AW+1:2];
	wire logic [MEM_AW-1:0] r_idx  = r_next[MEM_AW+1:2];
	wire logic [MEM_AW-1:0] a_idx  = araddr[MEM_AW+1:2];
	wire logic              w_bad  = waddr_reg >= MEM_LIMIT;
	wire logic              r_bad  = r_next >= MEM_LIMIT;
	wire logic              a_bad  = araddr >= MEM_LIMIT;
	// Write last seen early or late marks the burst as a slave error.
	wire logic w_final   = wcnt_reg == wlen_reg; // RULE25
	wire logic w_mismatch = (wlast != w_final) | (wid != bid); // RULE4
	wire logic r_final   = rcnt_reg == rlen_reg; // RULE10
	wire logic [1:0] w_ok = wexcl_reg ? RESP_EXOKAY : RESP_OKAY;
	wire logic [1:0] ar_ok = (arlock == LOCK_EXCL) ? RESP_EXOKAY : RESP_OKAY;
	wire logic [1:0] r_ok = rexcl_reg ? RESP_EXOKAY : RESP_OKAY;

	// Byte lanes of the addressed word update only where strobed.
	for (genvar b = 0; b < STRB_W; b++) begin : g_lane
		logic [7:0] lane_reg [MEM_WORDS];
		always_ff @(posedge sys_clk) begin
			if (w_fire && wstrb[b] && !w_bad) begin // RULE3
				lane_reg[w_idx] <= wdata[8*b +: 8]; // RULE2
			end
		end
		assign a_word[8*b +: 8] = lane_reg[a_idx];
		assign n_word[8*b +: 8] = lane_reg[r_idx];
	end

	// Write path: address, data beats, then one response.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ws_reg     <= WS_ADDR;
			awready    <= 1'b0;
			wready     <= 1'b0;
			bvalid     <= 1'b0;
			bid        <= RST_ID;
			bresp      <= RESP_OKAY;
			waddr_reg  <= RST_ADDR;
			wsize_reg  <= 3'h0;
			wburst_reg <= BURST_FIXED;
			wlen_reg   <= RST_LEN;
			wcnt_reg   <= RST_LEN;
			werr_reg   <= 1'b0;
			wexcl_reg  <= 1'b0;
		end else begin
			unique case (ws_reg)
				WS_ADDR: begin
					awready <= ~aw_fire; // RULE22
					if (aw_fire) begin
						bid        <= awid; // RULE6
						waddr_reg  <= awaddr;
						wsize_reg  <= awsize;
						wburst_reg <= awburst;
						wlen_reg   <= awlen;
						wcnt_reg   <= RST_LEN;
						werr_reg   <= 1'b0;
						wexcl_reg  <= awlock == LOCK_EXCL;
						wready     <= 1'b1; // RULE5
						ws_reg     <= WS_DATA;
					end
				end
				WS_DATA: begin
					if (w_fire) begin
						waddr_reg <= w_next; // RULE12
						wcnt_reg  <= wcnt_reg + 4'h1;
						werr_reg  <= werr_reg | w_mismatch | w_bad;
						if (wlast) begin
							wready <= 1'b0;
							bvalid <= 1'b1; // RULE8
							bresp  <= (werr_reg | w_mismatch | w_bad) ?
								RESP_SLVERR : w_ok; // RULE7 RULE24
							ws_reg <= WS_RESP;
						end
					end
				end
				WS_RESP: begin
					if (b_fire) begin
						bvalid  <= 1'b0;
						awready <= 1'b1; // RULE15
						ws_reg  <= WS_ADDR;
					end
				end
			endcase
		end
	end

	// Read path: take one address, then return len+1 beats.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rs_reg     <= RS_ADDR;
			arready    <= 1'b0;
			rvalid     <= 1'b0;
			rlast      <= 1'b0;
			rid        <= RST_ID;
			rdata      <= RST_DATA;
			rresp      <= RESP_OKAY;
			raddr_reg  <= RST_ADDR;
			rsize_reg  <= 3'h0;
			rburst_reg <= BURST_FIXED;
			rlen_reg   <= RST_LEN;
			rcnt_reg   <= RST_LEN;
			rexcl_reg  <= 1'b0;
		end else begin
			unique case (rs_reg)
				RS_ADDR: begin
					arready <= ~ar_fire; // RULE15
					if (ar_fire) begin
						rid        <= arid; // RULE16
						raddr_reg  <= araddr; // RULE9
						rsize_reg  <= arsize; // RULE11
						rburst_reg <= arburst;
						rlen_reg   <= arlen;
						rcnt_reg   <= RST_LEN;
						rexcl_reg  <= arlock == LOCK_EXCL; // RULE13
						rdata      <= a_bad ? RST_DATA : a_word; // RULE17
						rresp      <= a_bad ? RESP_DECERR : ar_ok; // RULE18 RULE24
						rlast      <= arlen == RST_LEN; // RULE19
						rvalid     <= 1'b1; // RULE20
						rs_reg     <= RS_DATA;
					end
				end
				RS_DATA: begin
					if (r_fire) begin
						if (r_final) begin // RULE10
							rvalid  <= 1'b0;
							rlast   <= 1'b0;
							arready <= 1'b1;
							rs_reg  <= RS_ADDR;
						end else begin
							raddr_reg <= r_next; // RULE12
							rcnt_reg  <= rcnt_reg + 4'h1;
							rdata     <= r_bad ? RST_DATA : n_word;
							rresp     <= r_bad ? RESP_DECERR : r_ok; // RULE18
							rlast     <= (rcnt_reg + 4'h1) == rlen_reg; // RULE19
						end
					end
				end
			endcase
		end
	end

	// Helper: beats accepted since the read address.
	logic [4:0] rbeats_reg;
	always_ff @(posedge sys_clk) begin
		if (sys_rst || ar_fire) begin
			rbeats_reg <= 5'h0;
		end else if (r_fire) begin
			rbeats_reg <= rbeats_reg + 5'h1;
		end
	end

	rlast_count_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		r_fire && rlast |-> rbeats_reg == {1'b0, rlen_reg}) // RULE10
		else $error("Read burst ended at the wrong beat count.");
	rlast_final_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rvalid |-> rlast == (rcnt_reg == rlen_reg)) // RULE19
		else $error("Read last does not match the final beat.");
	rvalid_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rid)) // RULE20
		else $error("Read beat dropped or changed before acceptance.");
	rid_match_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ar_fire |=> rid == $past(arid) && rvalid) // RULE16
		else $error("Read ID differs from address ID.");
	bid_match_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		aw_fire |=> bid == $past(awid)) // RULE6
		else $error("Write response ID differs from address ID.");
	bvalid_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		bvalid && !bready |=> bvalid && $stable(bresp)) // RULE8
		else $error("Write response dropped before acceptance.");
	bresp_after_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		w_fire && wlast |=> bvalid && !wready) // RULE7
		else $error("No write response after the last beat.");
	arready_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		arready |-> rs_reg == RS_ADDR && !rvalid) // RULE15
		else $error("Read address ready while busy.");
	wready_busy_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wready |-> ws_reg == WS_DATA && !bvalid) // RULE5
		else $error("Write ready outside the data phase.");
endmodule // axs_slave

// ===== verification/axs_master_model.sv
// Master-side model that drives the slave's request channels.
// Assumes the bench calls its tasks one channel pair at a time.
`timescale 1ns/1ps
module axs_master_model
	import axs_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        awready,
	input  wire logic        wready,
	input  wire logic        bvalid,
	input  wire logic        arready,
	input  wire logic        rvalid,
	input  wire logic        rlast,
	output logic      [3:0]  awid,
	output logic      [31:0] awaddr,
	output logic      [3:0]  awlen,
	output logic      [2:0]  awsize,
	output logic      [1:0]  awburst,
	output logic      [1:0]  awlock,
	output logic      [3:0]  awcache,
	output logic      [2:0]  awprot,
	output logic             awvalid,
	output logic      [3:0]  wid,
	output logic      [31:0] wdata,
	output logic      [3:0]  wstrb,
	output logic             wlast,
	output logic             wvalid,
	output logic             bready,
	output logic      [3:0]  arid,
	output logic      [31:0] araddr,
	output logic      [3:0]  arlen,
	output logic      [2:0]  arsize,
	output logic      [1:0]  arburst,
	output logic      [1:0]  arlock,
	output logic      [3:0]  arcache,
	output logic      [2:0]  arprot,
	output logic             arvalid,
	output logic             rready
);
	initial begin
		{awid, awaddr, awlen, awsize, awburst, awlock, awcache, awprot} = '0;
		{wid, wdata, wstrb, wlast, awvalid, wvalid, bready} = '0;
		{arid, araddr, arlen, arsize, arburst, arlock, arcache} = '0;
		{arprot, arvalid, rready} = '0;
	end

	task automatic wr(input logic [3:0] id, input logic [3:0] did,
		input logic [31:0] a, input logic [3:0] n, input logic [1:0] lk,
		input logic [31:0] d [16], input logic [3:0] s);
		@(negedge sys_clk);
		{awid, awaddr, awlen, awlock} = {id, a, n, lk};
		{awsize, awburst} = {3'h2, BURST_INCR};
		{awcache, awprot} = 7'($urandom);
		awvalid = 1'b1;
		while (!awready) @(negedge sys_clk);
		@(negedge sys_clk);
		awvalid = 1'b0;
		awaddr = ~awaddr;
		for (int i = 0; i <= n; i++) begin
			if ($urandom_range(1)) begin
				wvalid = 1'b0;
				@(negedge sys_clk);
			end
			{wid, wdata, wstrb, wlast} = {did, d[i], s, i == n};
			wvalid = 1'b1;
			while (!wready) @(negedge sys_clk);
			@(negedge sys_clk);
		end
		wvalid = 1'b0;
		wdata = ~wdata;
		repeat ($urandom_range(2)) @(negedge sys_clk);
		bready = 1'b1;
		while (!bvalid) @(negedge sys_clk);
		@(negedge sys_clk);
		bready = 1'b0;
	endtask

	task automatic rd(input logic [3:0] id, input logic [31:0] a,
		input logic [3:0] n, input logic [1:0] b, input logic [1:0] lk,
		input logic [2:0] z);
		logic done;
		@(negedge sys_clk);
		{arid, araddr, arlen, arburst, arlock} = {id, a, n, b, lk};
		{arsize, arcache, arprot} = {z, 7'($urandom)};
		arvalid = 1'b1;
		while (!arready) @(negedge sys_clk);
		@(negedge sys_clk);
		arvalid = 1'b0;
		araddr = ~araddr;
		do begin
			rready = 1'($urandom_range(1));
			done = rvalid && rready && rlast;
			@(negedge sys_clk);
		end while (!done);
		rready = 1'b0;
	endtask
endmodule // axs_master_model

// ===== verification/axs_slave_tb.sv
// Self-checking bench for the slave endpoint with a master model.
// Assumes registered slave outputs that change only on rising edges.
`timescale 1ns/1ps
module axs_slave_tb;
	import axs_pkg::*;
	logic sys_clk, sys_rst, awvalid, awready, wlast, wvalid, wready;
	logic bvalid, bready, arvalid, arready, rlast, rvalid, rready;
	logic [3:0] awid, wid, bid, arid, rid, awlen, arlen, wstrb;
	logic [31:0] awaddr, araddr, wdata, rdata;
	logic [3:0] awcache, arcache;
	logic [2:0] awsize, awprot, arsize, arprot;
	logic [1:0] awburst, awlock, bresp, arburst, arlock, rresp;
	logic [31:0] mem [64];
	logic [38:0] rq [$];
	logic [5:0] bq [$];
	int err_total = 0;
	int check_count = 0;
	int cycles = 0;

	axs_slave i_dut (.*);
	axs_master_model i_mst (.*);

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic chk(input string nm, input logic [38:0] e,
		input logic [38:0] s);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic wr(input logic [3:0] id, input logic [3:0] did,
		input logic [31:0] a, input logic [3:0] n, input logic [1:0] lk,
		input logic [3:0] s);
		logic [31:0] d [16];
		logic [1:0] e;
		e = lk == LOCK_EXCL ? RESP_EXOKAY : RESP_OKAY;
		if (did != id || a >= MEM_LIMIT)
			e = RESP_SLVERR;
		for (int i = 0; i < 16; i++) begin
			d[i] = $urandom;
			for (int j = 0; j < 4; j++)
				if (e != RESP_SLVERR && i <= n && s[j])
					mem[a[7:2] + i][8*j +: 8] = d[i][8*j +: 8];
		end
		bq.push_back({id, e});
		i_mst.wr(id, did, a, n, lk, d, s);
		chk("wdone", 39'({awready, wready, bvalid}), 39'h4);
		$display("write at %h done", a);
	endtask

	task automatic rd(input logic [3:0] id, input logic [31:0] a,
		input logic [3:0] n, input logic [1:0] b, input logic [1:0] lk,
		input logic [2:0] z);
		logic [31:0] p;
		logic [31:0] m;
		logic [1:0] e;
		p = a;
		m = ((32'(n) + 32'h1) << z) - 32'h1;
		for (int i = 0; i <= n; i++) begin
			e = lk == LOCK_EXCL ? RESP_EXOKAY : RESP_OKAY;
			if (p >= MEM_LIMIT)
				e = RESP_DECERR;
			rq.push_back({id, e, i == n, e == RESP_DECERR ? 32'h0 : mem[p[7:2]]});
			if (b == BURST_INCR)
				p = p + (32'h1 << z);
			if (b == BURST_WRAP)
				p = (p & ~m) | ((p + (32'h1 << z)) & m);
		end
		i_mst.rd(id, a, n, b, lk, z);
		chk("rdone", 39'({arready, rvalid}), 39'h2);
		$display("read at %h done", a);
	endtask

	always @(posedge sys_clk) begin
		if (!sys_rst && rvalid === 1'b1 && rready)
			chk("rbeat", rq.pop_front(), {rid, rresp, rlast, rdata});
		if (!sys_rst && bvalid === 1'b1 && bready)
			chk("bresp", 39'(bq.pop_front()), 39'({bid, bresp}));
	end

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			err_total++;
			stop_test();
		end
	end

	initial begin
		sys_rst = 1'b1;
		void'($urandom(32'hfb6c));
		repeat (12) @(negedge sys_clk);
		sys_rst = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk("idle", 39'({awready, arready, bvalid, rvalid}), 39'h0c);
		wr(4'h3, 4'h3, 32'h0, 4'hf, 2'h0, 4'hf);
		wr(4'h1, 4'h1, 32'h8, 4'h0, LOCK_EXCL, 4'($urandom));
		rd(4'h5, 32'h0, 4'hf, BURST_INCR, 2'h0, 3'h2);
		rd(4'ha, 32'hc, 4'h3, BURST_WRAP, LOCK_EXCL, 3'h2);
		rd(4'h6, 32'h4, 4'h2, BURST_FIXED, 2'h0, 3'h2);
		rd(4'h8, 32'h2, 4'h3, BURST_INCR, 2'h0, 3'h1);
		rd(4'hf, 32'h100, 4'h1, BURST_INCR, 2'h0, 3'h2);
		wr(4'h2, 4'h6, 32'hf0, 4'h1, 2'h0, 4'hf);
		wr(4'h4, 4'h4, 32'h100, 4'h0, 2'h0, 4'hf);
		fork
			wr(4'h7, 4'h7, 32'h40, 4'h3, 2'h0, 4'hf);
			rd(4'h9, 32'h20, 4'h7, BURST_INCR, 2'h0, 3'h2);
		join
		repeat (2) @(negedge sys_clk);
		chk("left", 39'(rq.size() + bq.size()), 39'h0);
		stop_test();
	end
endmodule // axs_slave_tb
